// ### core/qbp_port.sv
// quasi-bidirectional address port plus upper half of interrupt port
// What this block does
// - pin4 alternate input: rising edge interrupt
// - pin5 alternate input: falling edge interrupt
// - pin6 alternate input: rising edge interrupt
// - pin7 alternate input: falling edge interrupt
// - address port latches reset to one
// - latch one: weak high, pin readable
// - written zero drives low until one
// - zero-to-one write gives brief strong high
// - after pulse, back to weak high
// - external fetch drives upper address bits
// - interrupt port latches reset to one
module qbp_port
  import qbp_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // address port latch write
  input  wire logic             addrWrEn,
  input  wire logic [7:0]       addrWrData,
  // external program fetch
  input  wire logic             extFetch,
  input  wire logic [7:0]       upperAddr,
  // address port pins; oe low while the pin is driven
  input  wire logic [7:0]       addrPinIn,
  output logic      [7:0]       addrPinOut,
  output logic      [7:0]       addrPinOe_n,
  output logic      [7:0]       addrPinStrong,
  output logic      [7:0]       addrPinRead,
  // interrupt port (pins 4..7) latch write
  input  wire logic             irqWrEn,
  input  wire logic [3:0]       irqWrData,
  // interrupt port pins
  input  wire logic [3:0]       irqPinIn,
  output logic      [3:0]       irqPinOe_n,
  output logic      [3:0]       irqPinStrongHigh,
  output logic      [3:0]       irqPinRead,
  // interrupt pending flags, cleared per bit
  input  wire logic [3:0]       irqClear,
  output logic      [3:0]       irqPending
);
  qbp_state_t sReg;
  qbp_state_t sNext;

  always_comb begin
    sNext = sReg;
    // two-stage sync of every pin; stage one feeds stage two only
    sNext.addrSync1   = addrPinIn;
    sNext.addrSync2   = sReg.addrSync1;
    sNext.irqPinSync1 = irqPinIn;
    sNext.irqPinSync2 = sReg.irqPinSync1;
    sNext.irqPrev     = sReg.irqPinSync2;
    // address port latch with zero-to-one kick
    if (addrWrEn) begin
      sNext.addrLatch = addrWrData;
      sNext.addrKick  = addrWrData & ~sReg.addrLatch;
      if ((addrWrData & ~sReg.addrLatch) != 8'h00) begin
        sNext.addrKickCnt = KICK_CYCLES;
      end
    end else if (sReg.addrKickCnt != 4'h0) begin
      sNext.addrKickCnt = sReg.addrKickCnt - 4'h1;
      if (sReg.addrKickCnt == 4'h1) begin
        sNext.addrKick = 8'h00;
      end
    end
    if (irqWrEn) begin
      sNext.irqLatch = irqWrData;
      sNext.irqKick  = irqWrData & ~sReg.irqLatch;
      if ((irqWrData & ~sReg.irqLatch) != 4'h0) begin
        sNext.irqKickCnt = KICK_CYCLES;
      end
    end else if (sReg.irqKickCnt != 4'h0) begin
      sNext.irqKickCnt = sReg.irqKickCnt - 4'h1;
      if (sReg.irqKickCnt == 4'h1) begin
        sNext.irqKick = 4'h0;
      end
    end
    // edge detect per source; set wins over clear
    for (int i = 0; i < IRQ_N; i++) begin
      sNext.irqPulse[i] = IRQ_RISING[i] ? (sReg.irqPinSync2[i] & ~sReg.irqPrev[i])
                                        : (~sReg.irqPinSync2[i] & sReg.irqPrev[i]);
    end
    sNext.irqPend = (sReg.irqPend & ~irqClear) | sNext.irqPulse;
    // pin drive: fetch overrides latch with the address byte
    if (extFetch) begin
      sNext.addrPinOut = upperAddr;
      sNext.addrPinOe  = 8'h00;
      sNext.addrStrong = 8'hFF;
    end else begin
      sNext.addrPinOut = 8'h00;
      sNext.addrPinOe  = sNext.addrLatch;
      sNext.addrStrong = ~sNext.addrLatch | sNext.addrKick;
      for (int i = 0; i < PORT_W; i++) begin
        if (sNext.addrKick[i]) begin
          sNext.addrPinOut[i] = 1'b1;
          sNext.addrPinOe[i]  = 1'b0;
        end
      end
    end
    // registered so the pin enable comes straight from a flip-flop
    sNext.irqSync1 = sNext.irqLatch & ~sNext.irqKick;
    sNext.irqSync2 = sNext.irqKick;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sReg             <= '0;
      sReg.addrLatch   <= LATCH_RESET;
      sReg.irqLatch    <= IRQ_RESET;
      sReg.addrPinOe   <= LATCH_RESET;
      sReg.irqSync1    <= IRQ_RESET;
      sReg.irqPinSync1 <= IRQ_RESET;
      sReg.irqPinSync2 <= IRQ_RESET;
      sReg.irqPrev     <= IRQ_RESET;
      sReg.addrSync1   <= LATCH_RESET;
      sReg.addrSync2   <= LATCH_RESET;
    end else begin
      sReg <= sNext;
    end
  end

  // irqSync1 holds the active-low enable, irqSync2 the strong-high kick for irq pins
  assign addrPinOut       = sReg.addrPinOut;
  assign addrPinOe_n      = sReg.addrPinOe;
  assign addrPinStrong    = sReg.addrStrong;
  assign addrPinRead      = sReg.addrSync2;
  assign irqPinOe_n       = sReg.irqSync1;
  assign irqPinStrongHigh = sReg.irqSync2;
  assign irqPinRead       = sReg.irqPinSync2;
  assign irqPending       = sReg.irqPend;

  reset_latch_a: assert property (@(posedge sys_clk) $rose(resetn) |-> addrPinOe_n == 8'hFF)
    else $error("address port not released high after reset");
  zero_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    addrWrEn && !extFetch && addrWrData[0] == 1'b0 |=> addrPinOe_n[0] == 1'b0 && addrPinOut[0] == 1'b0)
    else $error("written zero not driven low");
  kick_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    addrWrEn && !extFetch && addrWrData[0] && !sReg.addrLatch[0] |=> addrPinOut[0] && addrPinStrong[0])
    else $error("no strong high after zero-to-one");
  kick_end_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(sReg.addrKick[0]) && !extFetch && sReg.addrLatch[0] |=> addrPinOe_n[0] && !addrPinStrong[0])
    else $error("pin not back to weak high");
  fetch_addr_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    extFetch |=> addrPinOut == $past(upperAddr) && addrPinOe_n == 8'h00)
    else $error("address byte not driven during fetch");
  rise_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(sReg.irqPinSync2[0]) |=> irqPending[0])
    else $error("rising edge on pin4 missed");
  fall_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(sReg.irqPinSync2[1]) |=> irqPending[1])
    else $error("falling edge on pin5 missed");
  rise_b_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(sReg.irqPinSync2[2]) |=> irqPending[2])
    else $error("rising edge on pin6 missed");
  fall_b_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(sReg.irqPinSync2[3]) |=> irqPending[3])
    else $error("falling edge on pin7 missed");
  sync_delay_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##2 irqPinRead == $past(irqPinIn, 2))
    else $error("interrupt pin sync depth wrong");
  irq_reset_a: assert property (@(posedge sys_clk) $rose(resetn) |-> irqPinOe_n == 4'hF)
    else $error("interrupt port not released high");
  weak_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##2 addrPinRead == $past(addrPinIn, 2))
    else $error("address pin read path wrong");

  // the interrupt port pins follow the same quasi-bidirectional scheme
  irq_low_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irqWrEn && irqWrData[0] == 1'b0 |=> !irqPinOe_n[0] && !irqPinStrongHigh[0])
    else $error("interrupt latch zero not driven low");
  irq_kick_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irqWrEn && irqWrData[0] && !sReg.irqLatch[0] |=> !irqPinOe_n[0] && irqPinStrongHigh[0])
    else $error("no strong high on interrupt pin after zero-to-one");
  irq_kick_end_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(sReg.irqKick[0]) && sReg.irqLatch[0] && !irqWrEn |=> irqPinOe_n[0])
    else $error("interrupt pin not back to weak high");

  // the kick length is fixed by the counter load, not by the write pattern
  kick_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(sReg.addrKick[0]) |-> sReg.addrKickCnt == KICK_CYCLES)
    else $error("kick counter not loaded with its length");
  fetch_strong_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    extFetch |=> addrPinStrong == 8'hFF)
    else $error("address byte not driven strongly during fetch");

  // a clear that meets a fresh edge must lose, or the event is dropped
  set_wins_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irqClear[1] && sNext.irqPulse[1] |=> irqPending[1])
    else $error("clear beat a new interrupt edge");

  // per-bit hold of the drive state while nothing is written
  for (genvar b = 0; b < PORT_W; b++) begin : g_bit_chk
    zero_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !sReg.addrLatch[b] && !addrWrEn && !extFetch |=> !addrPinOe_n[b])
      else $error("written zero released without a write");
    weak_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      sReg.addrLatch[b] && !sReg.addrKick[b] && !addrWrEn && !extFetch |=> addrPinOe_n[b])
      else $error("latched one not left at weak high");
  end

  // pending flags are sticky until software clears them
  for (genvar k = 0; k < IRQ_N; k++) begin : g_pend_chk
    pend_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      irqPending[k] && !irqClear[k] |=> irqPending[k])
      else $error("pending flag dropped without a clear");
  end

  kick_seen_c: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(sReg.addrKick[0]));
  irq_kick_c:  cover property (@(posedge sys_clk) disable iff (!resetn) $rose(sReg.irqKick[0]));
  fetch_c:     cover property (@(posedge sys_clk) disable iff (!resetn) extFetch ##1 !extFetch);
  pend_c:      cover property (@(posedge sys_clk) disable iff (!resetn) irqPending == 4'hF);
  clr_c:       cover property (@(posedge sys_clk) disable iff (!resetn) |(irqClear & sNext.irqPulse));
endmodule

// ### core/qbp_pkg.sv
// package: constants for the quasi-bidirectional ports with edge interrupts
package qbp_pkg;
  localparam int          PORT_W      = 8;
  localparam int          IRQ_N       = 4;
  localparam int          IRQ_BASE    = 4;
  localparam logic [7:0]  LATCH_RESET = 8'hFF;
  localparam logic [3:0]  IRQ_RESET   = 4'hF;
  // 1 = rising edge, 0 = falling edge, per interrupt source (pins 4..7)
  localparam logic [3:0]  IRQ_RISING  = 4'h5;
  // strong high pulse after a 0->1 latch change
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          KICK_TIME_NS  = 20;
  localparam int          KICK_CYC_INT  = (KICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  KICK_CYCLES   = 4'(KICK_CYC_INT < 1 ? 1 : KICK_CYC_INT);
  typedef struct packed {
    logic [7:0] addrLatch;
    logic [7:0] addrKick;
    logic [3:0] addrKickCnt;
    logic [3:0] irqLatch;
    logic [3:0] irqKick;
    logic [3:0] irqKickCnt;
    logic [3:0] irqSync1;
    logic [3:0] irqSync2;
    logic [3:0] irqPrev;
    logic [3:0] irqPulse;
    logic [3:0] irqPend;
    logic [7:0] addrSync1;
    logic [7:0] addrSync2;
    logic [3:0] irqPinSync1;
    logic [3:0] irqPinSync2;
    logic [7:0] addrPinOut;
    logic [7:0] addrPinOe;
    logic [7:0] addrStrong;
  } qbp_state_t;
endpackage

// ### bench/qbp_pin_model.sv
// pin model: weak pullups on the address port, outside circuits on both ports
module qbp_pin_model
  import qbp_pkg::*;
(
  // address port
  input  wire logic [7:0] addrPinOut,
  input  wire logic [7:0] addrPinOe_n,
  input  wire logic [7:0] extPullLow,
  output logic      [7:0] addrPinIn,
  // interrupt port
  input  wire logic [3:0] irqPinOe_n,
  input  wire logic [3:0] irqPinStrongHigh,
  input  wire logic [3:0] extIrqLevel,
  output logic      [3:0] irqPinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // a released pin rests at the weak pullup unless pulled low outside
      addrPinIn[i] = !addrPinOe_n[i] ? addrPinOut[i] : !extPullLow[i];
    end
    for (int i = 0; i < 4; i++) begin
      // the outside source only reaches the pin while its latch is one
      irqPinIn[i] = !irqPinOe_n[i] ? irqPinStrongHigh[i] : extIrqLevel[i];
    end
  end
endmodule

// ### bench/tb.sv
// testbench: reset, latch drive, outside pull, fetch and edge interrupts
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import qbp_pkg::*;
  logic       sys_clk, resetn, addrWrEn, extFetch;
  logic [7:0] addrWrData, upperAddr, addrPinIn, addrPinOut, addrPinOe_n, addrPinStrong;
  logic [7:0] addrPinRead, extPullLow;
  logic [3:0] irqPinIn, irqPinOe_n, irqPinStrongHigh, irqPinRead, irqClear, irqPending;
  logic [3:0] extIrqLevel, irqWrData;
  logic       irqWrEn;
  int         err_total, tests_run;
  qbp_port qbp_port_inst (.sys_clk(sys_clk), .resetn(resetn), .addrWrEn(addrWrEn),
    .addrWrData(addrWrData), .extFetch(extFetch), .upperAddr(upperAddr),
    .addrPinIn(addrPinIn), .addrPinOut(addrPinOut), .addrPinOe_n(addrPinOe_n),
    .addrPinStrong(addrPinStrong), .addrPinRead(addrPinRead), .irqWrEn(irqWrEn),
    .irqWrData(irqWrData), .irqPinIn(irqPinIn), .irqPinOe_n(irqPinOe_n),
    .irqPinStrongHigh(irqPinStrongHigh), .irqPinRead(irqPinRead),
    .irqClear(irqClear), .irqPending(irqPending));
  qbp_pin_model qbp_pin_model_inst (.addrPinOut(addrPinOut), .addrPinOe_n(addrPinOe_n),
    .extPullLow(extPullLow), .addrPinIn(addrPinIn), .irqPinOe_n(irqPinOe_n),
    .irqPinStrongHigh(irqPinStrongHigh), .extIrqLevel(extIrqLevel), .irqPinIn(irqPinIn));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // lands one cycle after the edge that takes the write
  task automatic wr(logic [7:0] d);
    @(posedge sys_clk);
    addrWrEn <= 1'b1;
    addrWrData <= d;
    @(posedge sys_clk);
    addrWrEn <= 1'b0;
    tick(1);
  endtask
  task automatic wi(logic [3:0] d);
    @(posedge sys_clk);
    irqWrEn <= 1'b1;
    irqWrData <= d;
    @(posedge sys_clk);
    irqWrEn <= 1'b0;
    tick(1);
  endtask
  task automatic clr;
    @(posedge sys_clk);
    irqClear <= 4'hF;
    @(posedge sys_clk);
    irqClear <= 4'h0;
    tick(1);
    chk("cleared", 8'h00, {4'h0, irqPending});
  endtask
  task automatic t_drive;
    wr(8'hF0);
    chk("low oe", 8'hF0, addrPinOe_n);
    chk("low out", 8'h00, addrPinOut & 8'h0F);
    tick(4);
    chk("held", 8'hF0, addrPinOe_n);
    wr(8'hFF);
    chk("kick out", 8'h0F, addrPinOut & 8'h0F);
    chk("kick strong", 8'h0F, addrPinStrong);
    chk("kick oe", 8'hF0, addrPinOe_n);
    tick(1);
    chk("weak oe", 8'hFF, addrPinOe_n);
    chk("weak strong", 8'h00, addrPinStrong);
  endtask
  task automatic t_pull;
    @(posedge sys_clk);
    extPullLow <= 8'h81;
    tick(3);
    chk("pulled", 8'h7E, addrPinRead);
    extPullLow <= 8'h00;
  endtask
  task automatic t_fetch;
    @(posedge sys_clk);
    extFetch <= 1'b1;
    upperAddr <= 8'hA5;
    tick(2);
    chk("fetch out", 8'hA5, addrPinOut);
    chk("fetch oe", 8'h00, addrPinOe_n);
    extFetch <= 1'b0;
    tick(2);
  endtask
  task automatic t_irq;
    @(posedge sys_clk);
    extIrqLevel <= 4'h0;
    tick(5);
    chk("fall pend", 8'h0A, {4'h0, irqPending});
    clr();
    extIrqLevel <= 4'hF;
    tick(5);
    chk("rise pend", 8'h05, {4'h0, irqPending});
    clr();
  endtask
  task automatic t_irqwr;
    wi(4'h0);
    chk("irq low oe", 8'h00, {4'h0, irqPinOe_n});
    chk("irq low strong", 8'h00, {4'h0, irqPinStrongHigh});
    tick(2);
    chk("irq read low", 8'h00, {4'h0, irqPinRead});
    wi(4'hF);
    chk("irq kick", 8'h0F, {4'h0, irqPinStrongHigh});
    chk("irq kick oe", 8'h00, {4'h0, irqPinOe_n});
    tick(1);
    chk("irq weak oe", 8'h0F, {4'h0, irqPinOe_n});
    chk("irq weak strong", 8'h00, {4'h0, irqPinStrongHigh});
    tick(4);
    chk("irq read high", 8'h0F, {4'h0, irqPinRead});
    chk("irq wr pend", 8'h0F, {4'h0, irqPending});
    clr();
  endtask
  task automatic results;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #50us;
    err_total++;
    results();
  end
  initial begin
    {resetn, addrWrEn, extFetch, addrWrData, upperAddr, irqClear, extPullLow} = '0;
    extIrqLevel = 4'hF;
    irqWrEn = 1'b0;
    irqWrData = 4'hF;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    tick(1);
    chk("rst oe", 8'hFF, addrPinOe_n);
    chk("rst read", 8'hFF, addrPinRead);
    chk("rst irq oe", 8'h0F, {4'h0, irqPinOe_n});
    chk("rst pend", 8'h00, {4'h0, irqPending});
    t_drive();
    t_pull();
    t_fetch();
    t_irq();
    t_irqwr();
    results();
  end
endmodule
